// >>> tb/euart_monitor.sv
// Port-level checks of the serial port
`timescale 1ns/10ps
module euart_monitor (
  input wire logic       core_clk,               // Clock
  input wire logic       rst,                    // Reset
  input wire logic [7:0] sfr_addr,               // Select
  input wire logic       sfr_wr,                 // Write
  input wire logic       sfr_rd,                 // Read
  input wire logic [7:0] sfr_wdata,              // Write data
  input wire logic [7:0] sfr_rdata,              // Read data
  input wire logic       rxd_in,                 // Rx pin
  input wire logic       rxd_out,                // Rx drive
  input wire logic       rxd_oe_n,               // Rx enable
  input wire logic       txd,                    // Tx line
  input wire logic       receive_complete_flag,  // Rx flag
  input wire logic       transmit_complete_flag, // Tx flag
  input wire logic       framing_error_flag      // Stop flag
);
  logic       w_ctl, w_pwr, w_dat, clr_ti, set_rf, clr_ef, set_ef;
  logic       busy, pend, ren_q, fcs_q;
  logic [1:0] mode_q;
  logic [7:0] sadr_q;
  assign w_ctl  = sfr_wr && sfr_addr == euart_pkg::ADDR_CTRL;
  assign w_pwr  = sfr_wr && sfr_addr == euart_pkg::ADDR_PWR;
  assign w_dat  = sfr_wr && sfr_addr == euart_pkg::ADDR_DATA;
  assign clr_ti = w_ctl && !sfr_wdata[euart_pkg::SC_TI];
  assign set_rf = w_ctl && sfr_wdata[euart_pkg::SC_RXF];
  assign clr_ef = w_pwr && !sfr_wdata[euart_pkg::PC_FEF];
  assign set_ef = w_pwr && sfr_wdata[euart_pkg::PC_FEF];
  // Shadow of settings and transmit activity
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy   <= 1'b0;
      pend   <= 1'b0;
      ren_q  <= 1'b0;
      fcs_q  <= 1'b0;
      mode_q <= 2'b00;
      sadr_q <= euart_pkg::SLA_RST;
    end else begin
      if (w_ctl) begin
        mode_q <= sfr_wdata[7:6];
        ren_q  <= sfr_wdata[euart_pkg::SC_REN];
      end
      if (w_pwr) fcs_q <= sfr_wdata[euart_pkg::PC_FCS];
      if (sfr_wr && sfr_addr == euart_pkg::ADDR_SLA) sadr_q <= sfr_wdata;
      if (w_dat) begin
        busy <= 1'b1;
        pend <= busy;
      end else if ($rose(transmit_complete_flag)) begin
        busy <= pend;
        pend <= 1'b0;
      end
    end
  end
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_fe_sticky: assert property (
    $fell(framing_error_flag) |-> $past(clr_ef) || $past(clr_ef, 2))
    else $error("framing flag fell without software clear");
  chk_ti_sticky: assert property (
    $fell(transmit_complete_flag) |-> $past(clr_ti) || $past(clr_ti, 2))
    else $error("transmit flag fell without software clear");
  chk_fe_needs_select: assert property (
    $rose(framing_error_flag) |-> fcs_q || $past(set_ef) || $past(set_ef, 2))
    else $error("framing flag set while checking off");
  chk_ri_needs_ren: assert property (
    $rose(receive_complete_flag) |-> ren_q || $past(set_rf) ||
      $past(set_rf, 2))
    else $error("receive flag set while reception disabled");
  chk_tx_start_bit: assert property (
    w_dat && !busy && mode_q != euart_pkg::MODE_SHIFT |-> ##[1:4] !txd)
    else $error("buffer write did not start a frame");
  chk_pin_drive_mode: assert property (
    !rxd_oe_n |-> mode_q == euart_pkg::MODE_SHIFT)
    else $error("receive pin driven outside shift mode");
  chk_unmapped_read: assert property (
    sfr_rd && sfr_addr > euart_pkg::ADDR_DIVHI ##1 !sfr_rd
      |=> sfr_rdata == euart_pkg::RD_UNMAPPED)
    else $error("unmapped read returned nonzero");
  chk_addr_readback: assert property (
    sfr_rd && sfr_addr == euart_pkg::ADDR_SLA ##1 !sfr_rd
      |=> sfr_rdata == sadr_q)
    else $error("slave address readback wrong");
  cov_rx_done: cover property ($rose(receive_complete_flag));
  cov_tx_done: cover property ($rose(transmit_complete_flag));
  cov_frame_err: cover property ($rose(framing_error_flag));
endmodule
bind euart_core euart_monitor u_monitor (.core_clk(core_clk), .rst(rst),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rxd_in(rxd_in),
  .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd),
  .receive_complete_flag(receive_complete_flag),
  .transmit_complete_flag(transmit_complete_flag),
  .framing_error_flag(framing_error_flag));

// >>> tb/euart_peer.sv
// Far-side serial controller model
`timescale 1ns/10ps
module euart_peer #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic core_clk, // Clock
  input  wire logic txd,      // Device line or shift clock
  output logic      line      // Toward device receive pin
);
  initial line = 1'b1;
  task automatic send(input logic [7:0] b, input logic nine,
                      input logic b9, input logic stop);
    logic [10:0] f;
    int          n;
    f = {stop, b9, b, 1'b0};
    n = nine ? 11 : 10;
    if (!nine) f[9] = stop;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      line <= f[i];
      repeat (BIT_CLKS - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    line <= 1'b1;
  endtask
  task automatic recv(output logic [7:0] b);
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge core_clk);
      b[i] = txd;
    end
  endtask
  task automatic shift(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      line <= b[i];
    end
    @(posedge txd);
    repeat (BIT_CLKS) @(posedge core_clk);
    line <= ~b[7];
  endtask
endmodule

// >>> tb/test_enhanced_uart_addr_match.sv
// Self-checking bench of the serial port
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[ERR] %0t got %h expected %h", $time, got, exp); \
    end \
  end
module test_enhanced_uart_addr_match;
  logic       core_clk;
  logic       rst;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  wire logic  rxd_in;
  logic       rxd_out, rxd_oe_n, txd, rxf, ti, fef, peer_line;
  int         errors = 0;
  int         check_count = 0;
  int         cycles = 0;
  euart_core #(.DIV_W(16)) dut (.core_clk(core_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd),
    .receive_complete_flag(rxf), .transmit_complete_flag(ti),
    .framing_error_flag(fef));
  euart_peer #(.BIT_CLKS(16)) peer (.core_clk(core_clk), .txd(txd),
    .line(peer_line));
  assign rxd_in = rxd_oe_n ? peer_line : rxd_out;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    d = sfr_rdata;
    `CHK(d, exp)
  endtask
  task automatic wait_flag(input logic tx, input int limit);
    for (int n = 0; n < limit && (tx ? ti : rxf) !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic t_regs();
    rdc(euart_pkg::ADDR_CTRL, 8'h00);
    rdc(euart_pkg::ADDR_PWR, 8'h00);
    rdc(euart_pkg::ADDR_SLA, 8'h00);
    rdc(euart_pkg::ADDR_SLM, 8'h00);
    rdc(8'h07, euart_pkg::RD_UNMAPPED);
    wr(euart_pkg::ADDR_DIVLO, 8'h00);
    wr(euart_pkg::ADDR_DIVHI, 8'h00);
  endtask
  task automatic t_duplex();
    logic [7:0] b;
    wr(euart_pkg::ADDR_CTRL, 8'h50);
    fork
      peer.send(8'h96, 1'b0, 1'b0, 1'b1);
      wr(euart_pkg::ADDR_DATA, 8'hA5);
      peer.recv(b);
    join
    `CHK(b, 8'hA5)
    wait_flag(1'b1, 64);
    `CHK(ti, 1'b1)
    `CHK(rxf, 1'b1)
    rdc(euart_pkg::ADDR_DATA, 8'h96);
    wr(euart_pkg::ADDR_CTRL, 8'h50);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(ti, 1'b0)
  endtask
  task automatic rx_time(input logic stop, output int n);
    n = 0;
    fork
      peer.send(8'h3C, 1'b0, 1'b0, stop);
      while (n < 400 && rxf !== 1'b1) begin
        @(posedge core_clk);
        #1;
        n++;
      end
    join
    wr(euart_pkg::ADDR_CTRL, 8'h50);
  endtask
  task automatic t_frame();
    int n0, n1, n2;
    rx_time(1'b1, n0);
    wr(euart_pkg::ADDR_PWR, 8'h40);
    rx_time(1'b1, n1);
    `CHK(n1 - n0, 16)
    `CHK(fef, 1'b0)
    rx_time(1'b0, n2);
    `CHK(fef, 1'b1)
    rx_time(1'b1, n2);
    `CHK(fef, 1'b1)
    wr(euart_pkg::ADDR_PWR, 8'h00);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(fef, 1'b0)
  endtask
  task automatic t_addr();
    logic [39:0] r;
    logic [39:0] rows [9] = '{40'hF05A010101, 40'hF0F0010101,
      40'hF0F2010100, 40'hF0FB010101, 40'hF0F0000100, 40'hB0F4010101,
      40'hD033000101, 40'h70F0000101, 40'h70F0000000};
    for (int i = 0; i < 9; i++) begin
      if (i == 1) begin
        wr(euart_pkg::ADDR_SLA, 8'hF1);
        wr(euart_pkg::ADDR_SLM, 8'hFA);
        rdc(euart_pkg::ADDR_SLM, 8'hFA);
        rdc(euart_pkg::ADDR_SLA, 8'hF1);
      end
      r = rows[i];
      wr(euart_pkg::ADDR_CTRL, r[39:32]);
      peer.send(r[31:24], r[39], r[16], r[8]);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK(rxf, r[0])
      if (r[0]) rdc(euart_pkg::ADDR_DATA, r[31:24]);
    end
  endtask
  task automatic t_mode0();
    logic [7:0] b;
    wr(euart_pkg::ADDR_DIVLO, 8'h07);
    fork
      wr(euart_pkg::ADDR_CTRL, 8'h30);
      peer.shift(8'h3C);
    join
    wait_flag(1'b0, 200);
    `CHK(rxf, 1'b1)
    rdc(euart_pkg::ADDR_DATA, 8'h3C);
    wr(euart_pkg::ADDR_CTRL, 8'h20);
    // Shift data leaves on the receive pin, stable at clock rise
    fork
      wr(euart_pkg::ADDR_DATA, 8'h81);
      for (int i = 0; i < 8; i++) begin
        @(posedge txd);
        b[i] = rxd_in;
      end
    join
    `CHK(b, 8'h81)
    wait_flag(1'b1, 400);
    `CHK(ti, 1'b1)
  endtask
  initial begin
    rst       = 1'b1;
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_duplex();
    t_frame();
    t_addr();
    t_mode0();
    final_report();
  end
endmodule

// >>> verilog/euart_core.sv
// Serial port, full-duplex in modes 1 to 3, with address recognition
`timescale 1ns/10ps
module euart_core #(
  parameter int DIV_W = 16
) (
  input  wire logic       core_clk,  // System clock
  input  wire logic       rst,       // Async reset, high
  input  wire logic [7:0] sfr_addr,  // Register select
  input  wire logic       sfr_wr,    // Write strobe
  input  wire logic       sfr_rd,    // Read strobe
  input  wire logic [7:0] sfr_wdata, // Write data
  output logic      [7:0] sfr_rdata, // Read data, next cycle
  input  wire logic       rxd_in,    // Receive pin input
  output logic            rxd_out,   // Receive pin drive
  output logic            rxd_oe_n,  // Receive pin enable, low
  output logic            txd,       // Transmit line / clock
  output logic            receive_complete_flag,  // Rx done
  output logic            transmit_complete_flag, // Tx done
  output logic            framing_error_flag      // Bad stop
);
  typedef struct packed {
    euart_pkg::euart_mode_t  mode;
    logic                    mp_en;
    logic                    ren;
    logic                    tb8;
    logic                    rb8;
    logic                    ti;
    logic                    rxf;
    logic                    fcs;
    logic                    fef;
    logic [7:0]              sla;
    logic [7:0]              slm;
    logic [7:0]              rbuf;
    logic [7:0]              thr;
    logic [7:0]              rdata;
    logic [DIV_W-1:0]        div;
    logic [DIV_W-1:0]        divcnt;
    logic                    tick;
    logic                    tx_pend;
    logic                    tx_act;
    logic [10:0]             tx_sh;
    logic [3:0]              tx_cnt;
    logic [3:0]              tx_sub;
    logic                    m0clk;
    logic                    txd;
    logic                    oe_n;
    euart_pkg::euart_rx_st_t rx_st;
    logic [7:0]              rx_data;
    logic                    rx_nin;
    logic                    rx_stop;
    logic                    rx_eval;
    logic                    rx_m0;
    logic                    rx_prev;
    logic [3:0]              rx_cnt;
    logic [3:0]              rx_sub;
  } euart_state_t;

  euart_state_t s;
  euart_state_t next_s;
  euart_rx_if   rxi ();

  euart_front u_front (
    .core_clk (core_clk),
    .rst      (rst),
    .rxd_pin  (rxd_in),
    .rxi      (rxi)
  );

  assign rxi.addr_byte = s.rx_data;
  assign rxi.sla       = s.sla;
  assign rxi.slm       = s.slm;

  logic       line;
  logic       m0;
  logic       m1;
  logic       early;
  logic       ninth;
  logic       accept;
  logic [3:0] nbits;
  logic [3:0] flen;
  logic [7:0] ctl_v;
  logic [7:0] pwr_v;

  assign line = rxi.rxd_clean;
  assign m0   = s.mode == euart_pkg::MODE_SHIFT;
  assign m1   = s.mode == euart_pkg::MODE_8BIT;

  always_comb begin
    next_s = s;
    ctl_v = 8'h00;
    pwr_v = 8'h00;
    ctl_v[euart_pkg::SC_RXF] = s.rxf;
    ctl_v[euart_pkg::SC_TI]  = s.ti;
    ctl_v[euart_pkg::SC_RB8] = s.rb8;
    ctl_v[euart_pkg::SC_TB8] = s.tb8;
    ctl_v[euart_pkg::SC_REN] = s.ren;
    ctl_v[euart_pkg::SC_MP]  = s.mp_en;
    ctl_v[euart_pkg::SC_MLO] = s.mode[0];
    ctl_v[euart_pkg::SC_MHI] = s.mode[1];
    pwr_v[euart_pkg::PC_FEF] = s.fef;
    pwr_v[euart_pkg::PC_FCS] = s.fcs;
    nbits = m1 ? euart_pkg::BITS_8 : euart_pkg::BITS_9;
    flen  = m1 ? euart_pkg::FRAME_8 : euart_pkg::FRAME_9;
    // Decision without framing check comes at last data bit, except in mode 1 with multiprocessor enabled
    early = !s.fcs && !(m1 && s.mp_en);
    ninth = m1 ? s.rx_stop : s.rx_nin;
    accept = 1'b0;

    // Register reads
    if (sfr_rd) begin
      unique case (sfr_addr)
        euart_pkg::ADDR_DATA:  next_s.rdata = s.rbuf;
        euart_pkg::ADDR_CTRL:  next_s.rdata = ctl_v;
        euart_pkg::ADDR_PWR:   next_s.rdata = pwr_v;
        euart_pkg::ADDR_SLA:   next_s.rdata = s.sla;
        euart_pkg::ADDR_SLM:   next_s.rdata = s.slm;
        euart_pkg::ADDR_DIVLO: next_s.rdata = s.div[7:0];
        euart_pkg::ADDR_DIVHI: next_s.rdata = s.div[15:8];
        default:               next_s.rdata = euart_pkg::RD_UNMAPPED;
      endcase
    end

    // Register writes; hardware sets below override clears
    if (sfr_wr) begin
      unique case (sfr_addr)
        euart_pkg::ADDR_DATA: begin
          next_s.thr = sfr_wdata;
          next_s.tx_pend = 1'b1;
        end
        euart_pkg::ADDR_CTRL: begin
          next_s.mode = euart_pkg::euart_mode_t'(
            {sfr_wdata[euart_pkg::SC_MHI],
             sfr_wdata[euart_pkg::SC_MLO]});
          next_s.mp_en = sfr_wdata[euart_pkg::SC_MP];
          next_s.ren   = sfr_wdata[euart_pkg::SC_REN];
          next_s.tb8   = sfr_wdata[euart_pkg::SC_TB8];
          next_s.rb8   = sfr_wdata[euart_pkg::SC_RB8];
          next_s.ti    = sfr_wdata[euart_pkg::SC_TI];
          next_s.rxf   = sfr_wdata[euart_pkg::SC_RXF];
        end
        euart_pkg::ADDR_PWR: begin
          next_s.fcs = sfr_wdata[euart_pkg::PC_FCS];
          next_s.fef = sfr_wdata[euart_pkg::PC_FEF];
        end
        euart_pkg::ADDR_SLA:   next_s.sla = sfr_wdata;
        euart_pkg::ADDR_SLM:   next_s.slm = sfr_wdata;
        euart_pkg::ADDR_DIVLO: next_s.div[7:0] = sfr_wdata;
        euart_pkg::ADDR_DIVHI: next_s.div[15:8] = sfr_wdata;
        default: ;
      endcase
    end

    // Bit-rate tick divider
    if (s.divcnt >= s.div) begin
      next_s.divcnt = '0;
      next_s.tick   = 1'b1;
    end else begin
      next_s.divcnt = s.divcnt + 1'b1;
      next_s.tick   = 1'b0;
    end

    if (!s.tx_act && s.tx_pend && !(m0 && s.rx_m0)) begin
      next_s.tx_act  = 1'b1;
      next_s.tx_pend = 1'b0;
      next_s.tx_cnt  = '0;
      next_s.tx_sub  = '0;
      if (m0) begin
        next_s.tx_sh = {3'b111, s.thr};
        next_s.m0clk = 1'b0;
      end else begin
        next_s.tx_sh = {1'b1, (m1 | s.tb8), s.thr, 1'b0};
      end
    end else if (s.tx_act && s.tick) begin
      if (m0) begin
        next_s.tx_sub = {3'b000, ~s.tx_sub[0]};
        if (!s.tx_sub[0]) begin
          next_s.m0clk = 1'b1;
        end else if (s.tx_cnt == euart_pkg::M0_LAST) begin
          next_s.tx_act = 1'b0;
          next_s.ti = 1'b1;
        end else begin
          next_s.m0clk  = 1'b0;
          next_s.tx_sh  = {1'b1, s.tx_sh[10:1]};
          next_s.tx_cnt = s.tx_cnt + 1'b1;
        end
      end else begin
        next_s.tx_sub = s.tx_sub + 1'b1;
        if (s.tx_sub == 4'hF) begin
          next_s.tx_sh  = {1'b1, s.tx_sh[10:1]};
          next_s.tx_cnt = s.tx_cnt + 1'b1;
          if (s.tx_cnt == flen - 1'b1) begin
            next_s.tx_act = 1'b0;
            next_s.ti = 1'b1;
          end
        end
      end
    end

    if (m0 && !s.rx_m0 && !s.tx_act && !s.tx_pend &&
        !s.rxf && s.ren && s.tick) begin
      next_s.rx_m0  = 1'b1;
      next_s.rx_cnt = '0;
      next_s.rx_sub = '0;
      next_s.m0clk  = 1'b0;
    end else if (s.rx_m0 && s.tick) begin
      next_s.rx_sub = {3'b000, ~s.rx_sub[0]};
      if (!s.rx_sub[0]) begin
        next_s.m0clk = 1'b1;
        next_s.rx_data[s.rx_cnt[2:0]] = line;
      end else if (s.rx_cnt == euart_pkg::M0_LAST) begin
        next_s.rx_m0 = 1'b0;
        next_s.m0clk = 1'b1;
        next_s.rbuf  = s.rx_data;
        next_s.rxf   = 1'b1;
      end else begin
        next_s.m0clk  = 1'b0;
        next_s.rx_cnt = s.rx_cnt + 1'b1;
      end
    end
    if (!m0) begin
      next_s.rx_m0 = 1'b0;
    end

    // Asynchronous receiver, modes 1 to 3
    next_s.rx_prev = line;
    next_s.rx_eval = 1'b0;
    unique case (s.rx_st)
      euart_pkg::RX_IDLE: begin
        if (!m0 && s.ren && s.rx_prev && !line) begin
          next_s.rx_st  = euart_pkg::RX_START;
          next_s.rx_sub = '0;
        end
      end
      euart_pkg::RX_START: begin
        if (s.tick) begin
          next_s.rx_sub = s.rx_sub + 1'b1;
          if (s.rx_sub == euart_pkg::SUB_MID) begin
            next_s.rx_cnt = '0;
            next_s.rx_st  = line ? euart_pkg::RX_IDLE
                                 : euart_pkg::RX_DATA;
          end
        end
      end
      euart_pkg::RX_DATA: begin
        if (s.tick) begin
          next_s.rx_sub = s.rx_sub + 1'b1;
          if (s.rx_sub == euart_pkg::SUB_MID) begin
            if (s.rx_cnt[3]) begin
              next_s.rx_nin = line;
            end else begin
              next_s.rx_data[s.rx_cnt[2:0]] = line;
            end
            next_s.rx_cnt = s.rx_cnt + 1'b1;
            if (s.rx_cnt == nbits - 1'b1) begin
              next_s.rx_st = euart_pkg::RX_STOP;
              if (early) begin
                next_s.rx_stop = 1'b1;
                next_s.rx_eval = 1'b1;
              end
            end
          end
        end
      end
      euart_pkg::RX_STOP: begin
        if (s.tick) begin
          next_s.rx_sub = s.rx_sub + 1'b1;
          if (s.rx_sub == euart_pkg::SUB_MID) begin
            next_s.rx_st = euart_pkg::RX_IDLE;
            if (s.fcs && !line) begin
              next_s.fef = 1'b1;
            end
            if (!early) begin
              next_s.rx_stop = line;
              next_s.rx_eval = 1'b1;
            end
          end
        end
      end
    endcase
    if (m0) begin
      next_s.rx_st = euart_pkg::RX_IDLE;
    end

    // Frame acceptance one cycle after the last sample
    if (s.rx_eval && !s.rxf) begin
      accept = !s.mp_en || (ninth && rxi.match);
    end
    if (accept) begin
      next_s.rbuf = s.rx_data;
      next_s.rb8  = ninth;
      next_s.rxf  = 1'b1;
    end

    // Pin drive: mode 0 clocks on the transmit pin
    next_s.txd  = (next_s.mode == euart_pkg::MODE_SHIFT) ?
                  next_s.m0clk :
                  (next_s.tx_act ? next_s.tx_sh[0] : 1'b1);
    next_s.oe_n = !((next_s.mode == euart_pkg::MODE_SHIFT) &&
                    next_s.tx_act);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.div     <= euart_pkg::DIV_RST;
      s.sla     <= euart_pkg::SLA_RST;
      s.slm     <= euart_pkg::SLM_RST;
      s.tx_sh   <= '1;
      s.m0clk   <= 1'b1;
      s.txd     <= 1'b1;
      s.oe_n    <= 1'b1;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sfr_rdata              = s.rdata;
  assign rxd_out                = s.tx_sh[0];
  assign rxd_oe_n               = s.oe_n;
  assign txd                    = s.txd;
  assign receive_complete_flag  = s.rxf;
  assign transmit_complete_flag = s.ti;
  assign framing_error_flag     = s.fef;
endmodule

// >>> verilog/euart_front.sv
// Line synchroniser and address comparator
`timescale 1ns/10ps
module euart_front (
  input  wire logic   core_clk, // System clock
  input  wire logic   rst,      // Async reset, high
  input  wire logic   rxd_pin,  // Raw receive line
  euart_rx_if.front   rxi       // Core side
);
  typedef struct packed {
    logic [2:0] sync;
    logic       clean;
  } euart_front_t;

  euart_front_t s;
  euart_front_t next_s;
  logic [7:0]   bcast;
  logic         given_hit;
  logic         bcast_hit;

  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[1:0], rxd_pin};
    // Level accepted once stages two and three agree
    if (s.sync[1] == s.sync[2]) begin
      next_s.clean = s.sync[2];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign given_hit = ((rxi.addr_byte ^ rxi.sla) & rxi.slm) == 8'h00;
  assign bcast     = rxi.sla | rxi.slm;
  assign bcast_hit = (rxi.addr_byte & bcast) == bcast;
  assign rxi.match     = given_hit | bcast_hit;
  assign rxi.rxd_clean = s.clean;
endmodule

// >>> verilog/euart_pkg.sv
// Constants, register map and types of the serial port
package euart_pkg;
  // Register select codes on the special-function bus
  localparam logic [7:0] ADDR_DATA  = 8'h00;
  localparam logic [7:0] ADDR_CTRL  = 8'h01;
  localparam logic [7:0] ADDR_PWR   = 8'h02;
  localparam logic [7:0] ADDR_SLA   = 8'h03;
  localparam logic [7:0] ADDR_SLM   = 8'h04;
  localparam logic [7:0] ADDR_DIVLO = 8'h05;
  localparam logic [7:0] ADDR_DIVHI = 8'h06;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Serial control register bit positions
  localparam int SC_RXF = 0;
  localparam int SC_TI  = 1;
  localparam int SC_RB8 = 2;
  localparam int SC_TB8 = 3;
  localparam int SC_REN = 4;
  localparam int SC_MP  = 5;
  localparam int SC_MLO = 6;
  localparam int SC_MHI = 7;
  // Power control register bit positions
  localparam int PC_FEF = 0;
  localparam int PC_FCS = 6;

  // Reset values
  localparam logic [7:0]  SLA_RST   = 8'h00;
  localparam logic [7:0]  SLM_RST   = 8'h00;
  localparam logic [15:0] DIV_RST   = 16'h006C;

  // Bit timing: sixteen ticks per bit in modes 1 to 3, sampled mid-bit; two ticks per bit in mode 0
  localparam logic [3:0] SUB_MID  = 4'h7;
  localparam logic [3:0] M0_LAST  = 4'h7;
  localparam logic [3:0] BITS_8   = 4'h8;
  localparam logic [3:0] BITS_9   = 4'h9;
  localparam logic [3:0] FRAME_8  = 4'hA;
  localparam logic [3:0] FRAME_9  = 4'hB;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8BIT  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } euart_mode_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } euart_rx_st_t;
endpackage

// >>> verilog/euart_rx_if.sv
// Signals between the receive front end and the core
`timescale 1ns/10ps
interface euart_rx_if;
  logic       rxd_clean;
  logic [7:0] addr_byte;
  logic [7:0] sla;
  logic [7:0] slm;
  logic       match;
  modport front (
    input  addr_byte, sla, slm,
    output rxd_clean, match
  );
  modport core (
    output addr_byte, sla, slm,
    input  rxd_clean, match
  );
endinterface
